// [wcr_pkg.sv]
// package of constants for the wake and transceiver mode register bank
// assumes an outside frame engine hands over complete 16-bit frames
// Functional notes
// - reserved bits always read back as zero
// - internal bit 6 enables cyclic timer wake
// - threshold field 5:4, code 00 highest
// - internal bit 2 disables watchdog in stop
// - internal bit 0 fast battery monitor, resets one
// - external bit 0 enables wake pin wake
// - fail-safe forces external wake register to 0x01
// - bias field 1:0 none, down, up, auto
// - bits 7/6 fast mode for transceivers two/one
// - mode low bits off, wake, receive, normal
// - device never alters selective wake top bit
// - sleep, no error, normal becomes wake capable
// - receive only: sleep to wake, stop keeps
// - off or wake capable kept on sleep/stop
// - fail-safe keeps at least one wake path

package wcr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register offsets (7-bit frame address)
  localparam logic [6:0] WCR_ADDR_INT_WAKE  = 7'h06;
  localparam logic [6:0] WCR_ADDR_EXT_WAKE  = 7'h07;
  localparam logic [6:0] WCR_ADDR_PIN_BIAS  = 7'h08;
  localparam logic [6:0] WCR_ADDR_XCVR_PAIR = 7'h0a;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] WCR_RST_INT_WAKE  = 8'h01;
  localparam logic [7:0] WCR_RST_EXT_WAKE  = 8'h01;
  localparam logic [7:0] WCR_RST_PIN_BIAS  = 8'h00;
  localparam logic [7:0] WCR_RST_XCVR_PAIR = 8'h00;
  // value forced into the external wake register on fail-safe entry
  localparam logic [7:0] WCR_FAILSAFE_EXT  = 8'h01;

  ////////////////////////////////////////////////////////////////////////
  // writable bit masks, zero bits are reserved
  localparam logic [7:0] WCR_MASK_INT_WAKE  = 8'h75;
  localparam logic [7:0] WCR_MASK_EXT_WAKE  = 8'h01;
  localparam logic [7:0] WCR_MASK_PIN_BIAS  = 8'h03;
  localparam logic [7:0] WCR_MASK_XCVR_PAIR = 8'hff;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int WCR_POS_CYCLIC_WAKE   = 6;
  localparam int WCR_POS_THRESH_HI     = 5;
  localparam int WCR_POS_THRESH_LO     = 4;
  localparam int WCR_POS_WDOG_STOP     = 2;
  localparam int WCR_POS_FAST_BATT     = 0;
  localparam int WCR_POS_PIN_WAKE      = 0;
  localparam int WCR_POS_PULL_HI       = 1;
  localparam int WCR_POS_PULL_LO       = 0;
  localparam int WCR_POS_FAST_TWO      = 7;
  localparam int WCR_POS_FAST_ONE      = 6;
  localparam int WCR_POS_MODE_TWO_HI   = 5;
  localparam int WCR_POS_MODE_TWO_LO   = 3;
  localparam int WCR_POS_MODE_ONE_HI   = 2;
  localparam int WCR_POS_MODE_ONE_LO   = 0;

  ////////////////////////////////////////////////////////////////////////
  // frame layout: address, write flag, data
  localparam int WCR_FRM_ADDR_HI = 6;
  localparam int WCR_FRM_WRITE   = 7;
  localparam int WCR_FRM_DATA_LO = 8;

  ////////////////////////////////////////////////////////////////////////
  // transceiver mode low-bit codes
  typedef enum logic [1:0] {
    WCR_XCVR_OFF     = 2'b00,
    WCR_XCVR_WAKE    = 2'b01,
    WCR_XCVR_RX_ONLY = 2'b10,
    WCR_XCVR_NORMAL  = 2'b11
  } wcr_xcvr_e;

  // bias codes of the wake pin
  typedef enum logic [1:0] {
    WCR_PULL_NONE = 2'b00,
    WCR_PULL_DOWN = 2'b01,
    WCR_PULL_UP   = 2'b10,
    WCR_PULL_AUTO = 2'b11
  } wcr_pull_e;

endpackage

// [wcr_frame_decode.sv]
// frame decoder: splits a completed 16-bit frame into address, data, strobes
// assumes frame_valid is a one-cycle pulse per finished frame
`timescale 1ns/1ps
`default_nettype none

module wcr_frame_decode
  import wcr_pkg::*;
(
  input  wire logic        clk_sys,     // system clock
  input  wire logic        sys_rst,     // synchronous reset, active high
  input  wire logic        frame_valid, // one frame complete
  input  wire logic [15:0] frame_word,  // frame contents
  output logic             wr_stb,      // write request pulse
  output logic             rd_stb,      // read request pulse
  output logic [6:0]       acc_addr,    // register address
  output logic [7:0]       acc_data     // write data
);

  ////////////////////////////////////////////////////////////////////////
  // state of the decoder
  typedef struct packed {
    logic       wr;   // write strobe
    logic       rd;   // read strobe
    logic [6:0] addr; // captured address
    logic [7:0] data; // captured data
  } wcr_dec_s;

  wcr_dec_s st_q; // registered state
  wcr_dec_s st_d; // next state

  // split the frame; strobes last exactly one cycle
  always_comb begin
    st_d    = st_q;
    st_d.wr = 1'b0;
    st_d.rd = 1'b0;
    if (frame_valid) begin
      st_d.addr = frame_word[WCR_FRM_ADDR_HI:0];
      st_d.data = frame_word[15:WCR_FRM_DATA_LO];
      st_d.wr   = frame_word[WCR_FRM_WRITE];
      st_d.rd   = ~frame_word[WCR_FRM_WRITE];
    end
  end

  // register the state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign wr_stb   = st_q.wr;
  assign rd_stb   = st_q.rd;
  assign acc_addr = st_q.addr;
  assign acc_data = st_q.data;

endmodule

`default_nettype wire

// [wcr_wake_can_regs.sv]
// wake source and transceiver mode register bank, top level
// assumes mode-entry and fail-safe inputs are one-cycle pulses on clk_sys
`timescale 1ns/1ps
`default_nettype none

module wcr_wake_can_regs
  import wcr_pkg::*;
(
  input  wire logic        clk_sys,                    // system clock
  input  wire logic        sys_rst,                    // sync reset, high
  input  wire logic        soft_reset,                 // soft reset pulse
  input  wire logic        frame_valid,                // frame complete
  input  wire logic [15:0] frame_word,                 // frame contents
  input  wire logic        sleep_entry,                // sleep mode entry
  input  wire logic        stop_entry,                 // stop mode entry
  input  wire logic        failsafe_entry,             // fail-safe entry
  input  wire logic [1:0]  system_error_flag,          // [0] one, [1] two
  input  wire logic        wdog_stop_hw_we,            // hw update of bit 2
  input  wire logic        wdog_stop_hw_val,           // hw value of bit 2
  output logic [7:0]       rd_data,                    // read answer
  output logic             rd_valid,                   // read answer pulse
  output logic             cyclic_wake_enable,         // timer wake source
  output logic [1:0]       batt_monitor_threshold_sel, // threshold code
  output logic [3:0]       batt_threshold_onehot,      // [0] highest
  output logic             wdog_stop_disable_hi,       // wdog off in stop
  output logic             fast_batt_monitor_enable,   // fast monitoring
  output logic             wake_pin_enable,            // pin wake source
  output logic [1:0]       wake_pin_pull_cfg,          // bias code
  output logic             wake_pin_pull_down,         // pull-down active
  output logic             wake_pin_pull_up,           // pull-up active
  output logic             wake_pin_pull_auto,         // auto switching
  output logic             xcvr_two_fast,              // no slew control
  output logic             xcvr_one_fast,              // no slew control
  output logic [2:0]       xcvr_two_mode,              // mode field two
  output logic [2:0]       xcvr_one_mode               // mode field one
);

  ////////////////////////////////////////////////////////////////////////
  // decoded register access from the frame decoder
  logic       wr_stb;   // write request
  logic       rd_stb;   // read request
  logic [6:0] acc_addr; // address of the request
  logic [7:0] acc_data; // write data

  wcr_frame_decode u_dec (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .frame_valid (frame_valid),
    .frame_word  (frame_word),
    .wr_stb      (wr_stb),
    .rd_stb      (rd_stb),
    .acc_addr    (acc_addr),
    .acc_data    (acc_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // mode field update on low-power or fail-safe entry
  // only the two low bits are touched, the selective wake bit is carried
  function automatic logic [2:0] wcr_mode_update(
    input logic [2:0] mode,   // current field
    input logic       sleep,  // sleep entry
    input logic       stop,   // stop entry
    input logic       fsafe,  // fail-safe entry
    input logic       syserr  // system error flag of this transceiver
  );
    logic [1:0] low;
    low = mode[1:0];
    if (fsafe) begin
      // any mode goes to wake capable so the bus can still wake
      low = WCR_XCVR_WAKE;
    end else if (sleep) begin
      case (low)
        WCR_XCVR_NORMAL: begin
          // normal becomes wake capable only without a system error
          if (!syserr) begin
            low = WCR_XCVR_WAKE;
          end
        end
        WCR_XCVR_RX_ONLY: begin
          // receive only is dropped to wake capable on sleep
          low = WCR_XCVR_WAKE;
        end
        default: begin
          // off and wake capable keep their code
          low = mode[1:0];
        end
      endcase
    end else if (stop) begin
      // stop keeps every mode, receive only included
      low = mode[1:0];
    end
    wcr_mode_update = {mode[2], low};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // whole state of the bank
  typedef struct packed {
    logic [7:0] int_wake;   // internal wake control
    logic [7:0] ext_wake;   // external wake control
    logic [7:0] pin_bias;   // wake pin bias control
    logic [7:0] xcvr_pair;  // transceiver pair control
    logic [7:0] rd_data;    // read answer
    logic       rd_valid;   // read answer pulse
    logic [3:0] thresh_oh;  // decoded threshold
    logic       pull_down;  // decoded bias
    logic       pull_up;    // decoded bias
    logic       pull_auto;  // decoded bias
  } wcr_bank_s;

  wcr_bank_s st_q; // registered state
  wcr_bank_s st_d; // next state

  // register select for the current request
  logic sel_int;  // internal wake selected
  logic sel_ext;  // external wake selected
  logic sel_bias; // pin bias selected
  logic sel_xcvr; // transceiver pair selected

  always_comb begin
    sel_int  = (acc_addr == WCR_ADDR_INT_WAKE);
    sel_ext  = (acc_addr == WCR_ADDR_EXT_WAKE);
    sel_bias = (acc_addr == WCR_ADDR_PIN_BIAS);
    sel_xcvr = (acc_addr == WCR_ADDR_XCVR_PAIR);
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic: host writes first, hardware updates override
  always_comb begin
    logic [2:0] m_one; // updated mode field one
    logic [2:0] m_two; // updated mode field two
    logic [1:0] thr;   // threshold code of the next state
    logic [1:0] pull;  // bias code of the next state
    m_one = 3'h0;
    m_two = 3'h0;
    thr   = 2'h0;
    pull  = 2'h0;
    st_d  = st_q;
    st_d.rd_valid = 1'b0;

    // host writes, reserved bits masked off
    if (wr_stb && sel_int) begin
      st_d.int_wake = acc_data & WCR_MASK_INT_WAKE;
    end
    if (wr_stb && sel_ext) begin
      st_d.ext_wake = acc_data & WCR_MASK_EXT_WAKE;
    end
    if (wr_stb && sel_bias) begin
      st_d.pin_bias = acc_data & WCR_MASK_PIN_BIAS;
    end
    if (wr_stb && sel_xcvr) begin
      st_d.xcvr_pair = acc_data & WCR_MASK_XCVR_PAIR;
    end

    // hardware update of the watchdog stop bit wins over the host
    if (wdog_stop_hw_we) begin
      st_d.int_wake[WCR_POS_WDOG_STOP] = wdog_stop_hw_val;
    end

    // fail-safe keeps the wake pin able to wake the device
    if (failsafe_entry) begin
      st_d.ext_wake = WCR_FAILSAFE_EXT;
    end

    // mode fields: hardware update is applied to the value of a same-cycle host write
    m_one = wcr_mode_update(
      st_d.xcvr_pair[WCR_POS_MODE_ONE_HI:WCR_POS_MODE_ONE_LO],
      sleep_entry, stop_entry, failsafe_entry, system_error_flag[0]);
    m_two = wcr_mode_update(
      st_d.xcvr_pair[WCR_POS_MODE_TWO_HI:WCR_POS_MODE_TWO_LO],
      sleep_entry, stop_entry, failsafe_entry, system_error_flag[1]);
    st_d.xcvr_pair[WCR_POS_MODE_ONE_HI:WCR_POS_MODE_ONE_LO] = m_one;
    st_d.xcvr_pair[WCR_POS_MODE_TWO_HI:WCR_POS_MODE_TWO_LO] = m_two;

    // threshold decode, code 00 is the highest threshold
    thr = st_d.int_wake[WCR_POS_THRESH_HI:WCR_POS_THRESH_LO];
    case (thr)
      2'h0: begin
        st_d.thresh_oh = 4'h1;
      end
      2'h1: begin
        st_d.thresh_oh = 4'h2;
      end
      2'h2: begin
        st_d.thresh_oh = 4'h4;
      end
      default: begin
        st_d.thresh_oh = 4'h8;
      end
    endcase

    // wake pin bias decode
    pull = st_d.pin_bias[WCR_POS_PULL_HI:WCR_POS_PULL_LO];
    st_d.pull_down = (pull == WCR_PULL_DOWN);
    st_d.pull_up   = (pull == WCR_PULL_UP);
    st_d.pull_auto = (pull == WCR_PULL_AUTO);

    // read answer from the stored values; unmapped reads return zero
    if (rd_stb) begin
      st_d.rd_valid = 1'b1;
      if (sel_int) begin
        st_d.rd_data = st_q.int_wake & WCR_MASK_INT_WAKE;
      end else if (sel_ext) begin
        st_d.rd_data = st_q.ext_wake & WCR_MASK_EXT_WAKE;
      end else if (sel_bias) begin
        st_d.rd_data = st_q.pin_bias & WCR_MASK_PIN_BIAS;
      end else if (sel_xcvr) begin
        st_d.rd_data = st_q.xcvr_pair;
      end else begin
        st_d.rd_data = 8'h00;
      end
    end

    // soft reset puts back the power-on values
    if (soft_reset) begin
      st_d.int_wake  = WCR_RST_INT_WAKE;
      st_d.ext_wake  = WCR_RST_EXT_WAKE;
      st_d.pin_bias  = WCR_RST_PIN_BIAS;
      st_d.xcvr_pair = WCR_RST_XCVR_PAIR;
      st_d.thresh_oh = 4'h1;
      st_d.pull_down = 1'b0;
      st_d.pull_up   = 1'b0;
      st_d.pull_auto = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register the state, power-on values on reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q.int_wake  <= WCR_RST_INT_WAKE;
      st_q.ext_wake  <= WCR_RST_EXT_WAKE;
      st_q.pin_bias  <= WCR_RST_PIN_BIAS;
      st_q.xcvr_pair <= WCR_RST_XCVR_PAIR;
      st_q.rd_data   <= 8'h00;
      st_q.rd_valid  <= 1'b0;
      st_q.thresh_oh <= 4'h1;
      st_q.pull_down <= 1'b0;
      st_q.pull_up   <= 1'b0;
      st_q.pull_auto <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, each a slice of the registered state
  assign rd_data  = st_q.rd_data;
  assign rd_valid = st_q.rd_valid;

  // internal wake control fields
  assign cyclic_wake_enable = st_q.int_wake[WCR_POS_CYCLIC_WAKE];
  assign batt_monitor_threshold_sel =
    st_q.int_wake[WCR_POS_THRESH_HI:WCR_POS_THRESH_LO];
  assign batt_threshold_onehot = st_q.thresh_oh;
  assign wdog_stop_disable_hi = st_q.int_wake[WCR_POS_WDOG_STOP];
  assign fast_batt_monitor_enable = st_q.int_wake[WCR_POS_FAST_BATT];

  // external wake and bias fields
  assign wake_pin_enable = st_q.ext_wake[WCR_POS_PIN_WAKE];
  assign wake_pin_pull_cfg =
    st_q.pin_bias[WCR_POS_PULL_HI:WCR_POS_PULL_LO];
  assign wake_pin_pull_down = st_q.pull_down;
  assign wake_pin_pull_up   = st_q.pull_up;
  assign wake_pin_pull_auto = st_q.pull_auto;

  // transceiver pair fields
  assign xcvr_two_fast = st_q.xcvr_pair[WCR_POS_FAST_TWO];
  assign xcvr_one_fast = st_q.xcvr_pair[WCR_POS_FAST_ONE];
  assign xcvr_two_mode =
    st_q.xcvr_pair[WCR_POS_MODE_TWO_HI:WCR_POS_MODE_TWO_LO];
  assign xcvr_one_mode =
    st_q.xcvr_pair[WCR_POS_MODE_ONE_HI:WCR_POS_MODE_ONE_LO];

endmodule

`default_nettype wire

// [wcr_wake_can_regs_properties.sv]
// concurrent checks on the wake and transceiver mode register bank
// assumes it is bound to wcr_wake_can_regs, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none

module wcr_props
  import wcr_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        soft_reset,
  input wire logic        frame_valid,
  input wire logic [15:0] frame_word,
  input wire logic        sleep_entry,
  input wire logic        stop_entry,
  input wire logic        failsafe_entry,
  input wire logic [1:0]  system_error_flag,
  input wire logic        wdog_stop_hw_we,
  input wire logic        wdog_stop_hw_val,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  input wire logic [1:0]  batt_monitor_threshold_sel,
  input wire logic [3:0]  batt_threshold_onehot,
  input wire logic        wdog_stop_disable_hi,
  input wire logic        wake_pin_enable,
  input wire logic [1:0]  wake_pin_pull_cfg,
  input wire logic        wake_pin_pull_down,
  input wire logic        wake_pin_pull_up,
  input wire logic        wake_pin_pull_auto,
  input wire logic [2:0]  xcvr_two_mode,
  input wire logic [2:0]  xcvr_one_mode
);
  // all checks share the system clock and its reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // bits that may read back as one, per address
  function automatic logic [7:0] live_bits(input logic [6:0] a);
    case (a)
      7'h06:   live_bits = 8'h75;
      7'h07:   live_bits = 8'h01;
      7'h08:   live_bits = 8'h03;
      7'h0a:   live_bits = 8'hff;
      default: live_bits = 8'h00;
    endcase
  endfunction

  // read frame taken with no soft reset while it is in flight
  sequence s_rd_req;
    (frame_valid && !frame_word[7] && !soft_reset) ##1 !soft_reset;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_rd_latency: assert property (s_rd_req |-> ##1 rd_valid)
    else $error("read answer missing two cycles after request");
  a_rd_source: assert property (rd_valid |-> $past(frame_valid, 2) &&
    !$past(frame_word[7], 2))
    else $error("read answer without a read request");
  a_resv_zero: assert property (rd_valid |->
    (rd_data & ~live_bits($past(frame_word[6:0], 2))) == 8'h00)
    else $error("reserved bit read back as one");
  a_fsafe_wake: assert property (failsafe_entry && !soft_reset |=>
    wake_pin_enable && xcvr_one_mode[1:0] == 2'b01 &&
    xcvr_two_mode[1:0] == 2'b01)
    else $error("fail-safe entry left no wake path");
  a_sleep_normal: assert property (sleep_entry && !failsafe_entry &&
    !soft_reset && xcvr_one_mode[1:0] == 2'b11 && !system_error_flag[0]
    |=> xcvr_one_mode == {$past(xcvr_one_mode[2]), 2'b01})
    else $error("normal transceiver not made wake capable on sleep");
  a_stop_keeps: assert property (stop_entry && !sleep_entry &&
    !failsafe_entry && !soft_reset && !$past(frame_valid)
    |=> $stable({xcvr_two_mode, xcvr_one_mode}))
    else $error("stop entry changed a transceiver mode");
  a_top_bits: assert property ($changed({xcvr_two_mode[2],
    xcvr_one_mode[2]}) |-> $past(sys_rst) || $past(soft_reset) ||
    ($past(frame_valid, 2) && $past(frame_word[7:0], 2) == 8'h8a))
    else $error("selective wake bit changed without host write");
  a_wdog_hw: assert property (wdog_stop_hw_we && !soft_reset |=>
    wdog_stop_disable_hi == $past(wdog_stop_hw_val))
    else $error("hardware watchdog stop update lost");
  a_onehot_map: assert property (batt_threshold_onehot ==
    4'b0001 << batt_monitor_threshold_sel)
    else $error("threshold one-hot does not match code");
  a_pull_map: assert property ({wake_pin_pull_auto, wake_pin_pull_up,
    wake_pin_pull_down} == {wake_pin_pull_cfg == 2'b11,
    wake_pin_pull_cfg == 2'b10, wake_pin_pull_cfg == 2'b01})
    else $error("pull outputs do not match bias code");
endmodule

bind wcr_wake_can_regs wcr_props chk_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .soft_reset(soft_reset),
  .frame_valid(frame_valid), .frame_word(frame_word),
  .sleep_entry(sleep_entry), .stop_entry(stop_entry),
  .failsafe_entry(failsafe_entry), .system_error_flag(system_error_flag),
  .wdog_stop_hw_we(wdog_stop_hw_we), .wdog_stop_hw_val(wdog_stop_hw_val),
  .rd_data(rd_data), .rd_valid(rd_valid),
  .batt_monitor_threshold_sel(batt_monitor_threshold_sel),
  .batt_threshold_onehot(batt_threshold_onehot),
  .wdog_stop_disable_hi(wdog_stop_disable_hi),
  .wake_pin_enable(wake_pin_enable), .wake_pin_pull_cfg(wake_pin_pull_cfg),
  .wake_pin_pull_down(wake_pin_pull_down),
  .wake_pin_pull_up(wake_pin_pull_up),
  .wake_pin_pull_auto(wake_pin_pull_auto),
  .xcvr_two_mode(xcvr_two_mode), .xcvr_one_mode(xcvr_one_mode)
);

`default_nettype wire

// [tb_wake_and_can_mode_regs.sv]
// self-checking bench for the wake and transceiver mode register bank
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb_wake_and_can_mode_regs import wcr_pkg::*;;
  logic clk_sys, sys_rst, soft_reset, frame_valid, sleep_entry, stop_entry;
  logic failsafe_entry, wdog_stop_hw_we, wdog_stop_hw_val, rd_valid;
  logic cyclic_wake_enable, wdog_stop_disable_hi, fast_batt_monitor_enable;
  logic wake_pin_enable, wake_pin_pull_down, wake_pin_pull_up;
  logic wake_pin_pull_auto, xcvr_two_fast, xcvr_one_fast;
  logic [15:0] frame_word;
  logic [7:0]  rd_data, d, exp_rd;             // exp_rd: monitor only
  logic [1:0]  system_error_flag, batt_monitor_threshold_sel;
  logic [1:0]  wake_pin_pull_cfg;
  logic [3:0]  batt_threshold_onehot;
  logic [2:0]  xcvr_two_mode, xcvr_one_mode;
  logic [7:0]  exp_q[$];                       // expected read answers
  logic [7:0]  v[5];                           // values written per round
  logic [6:0]  adr[5] = '{7'h06, 7'h07, 7'h08, 7'h0a, 7'h05};
  logic [7:0]  msk[5] = '{8'h75, 8'h01, 8'h03, 8'hff, 8'h00};
  int          num_errors, num_checks, seed;

  wcr_wake_can_regs dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .soft_reset(soft_reset),
    .frame_valid(frame_valid), .frame_word(frame_word),
    .sleep_entry(sleep_entry), .stop_entry(stop_entry),
    .failsafe_entry(failsafe_entry), .system_error_flag(system_error_flag),
    .wdog_stop_hw_we(wdog_stop_hw_we), .wdog_stop_hw_val(wdog_stop_hw_val),
    .rd_data(rd_data), .rd_valid(rd_valid),
    .cyclic_wake_enable(cyclic_wake_enable),
    .batt_monitor_threshold_sel(batt_monitor_threshold_sel),
    .batt_threshold_onehot(batt_threshold_onehot),
    .wdog_stop_disable_hi(wdog_stop_disable_hi),
    .fast_batt_monitor_enable(fast_batt_monitor_enable),
    .wake_pin_enable(wake_pin_enable), .wake_pin_pull_cfg(wake_pin_pull_cfg),
    .wake_pin_pull_down(wake_pin_pull_down),
    .wake_pin_pull_up(wake_pin_pull_up),
    .wake_pin_pull_auto(wake_pin_pull_auto),
    .xcvr_two_fast(xcvr_two_fast), .xcvr_one_fast(xcvr_one_fast),
    .xcvr_two_mode(xcvr_two_mode), .xcvr_one_mode(xcvr_one_mode)
  );

  ////////////////////////////////////////////////////////////////////////
  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // drive just after the rising edge
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  // drop all strobes, then wait n cycles
  task automatic idle(input int n);
    {frame_valid, sleep_entry, stop_entry, failsafe_entry} = 4'h0;
    {soft_reset, wdog_stop_hw_we} = 2'b00;
    repeat (n) tick;
  endtask

  // one write frame, held for one edge
  task automatic wr(input logic [6:0] a, input logic [7:0] val);
    frame_valid = 1'b1;
    frame_word = {val, 1'b1, a};
    tick;
  endtask

  // one read frame, answer noted for the monitor
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    frame_valid = 1'b1;
    frame_word = {8'h00, 1'b0, a};
    exp_q.push_back(e);
    tick;
  endtask

  // pulse one mode event: 0 sleep, 1 stop, 2 fail-safe
  task automatic ev(input int n);
    {frame_valid, sleep_entry, stop_entry, failsafe_entry} = 4'b0100 >> n;
    tick;
    idle(1);
  endtask

  // mode field after an event, low bits only may move
  function automatic logic [2:0] nx(input logic [2:0] m, input logic err,
                                    input logic slp);
    nx = m;
    if (slp && (m[1:0] == 2'b10 || (m[1:0] == 2'b11 && !err)))
      nx[1:0] = 2'b01;
  endfunction

  // reset image of every register plus an unmapped place
  task automatic chk_rst;
    for (int i = 0; i < 5; i++)
      rd(adr[i], (i < 2) ? 8'h01 : 8'h00);
    idle(3);
    `CHK("fast_batt", 1'b1, fast_batt_monitor_enable)
    `CHK("onehot", 4'b0001, batt_threshold_onehot)
  endtask

  task automatic wrap_up;
    `CHK("pending", 0, exp_q.size())
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // monitor: each read answer takes the oldest note
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      exp_rd = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHK("rd_data", exp_rd, rd_data)
    end
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    wrap_up;
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'hca12;
    {num_errors, num_checks} = '0;
    frame_word = 16'h0000;
    {system_error_flag, wdog_stop_hw_val} = 3'b000;
    sys_rst = 1'b1;
    idle(10);
    sys_rst = 1'b0;
    chk_rst;
    // back-to-back writes, all ones first, then random, threshold and bias codes stepped by one each round
    for (int r = 0; r < 6; r++) begin
      for (int i = 0; i < 5; i++) begin
        v[i] = (r == 0) ? 8'hff : 8'($random(seed));
        if (i == 0 || i == 2) v[i][1 + 4 * (i == 0) -: 2] = 2'(r + 1);
        wr(adr[i], v[i]);
      end
      idle(3);
      for (int i = 0; i < 5; i++) rd(adr[i], v[i] & msk[i]);
      `CHK("cyclic", v[0][6], cyclic_wake_enable)
      `CHK("thresh", v[0][5:4], batt_monitor_threshold_sel)
      `CHK("onehot", 4'b0001 << v[0][5:4], batt_threshold_onehot)
      `CHK("wdog", v[0][2], wdog_stop_disable_hi)
      `CHK("fast_batt", v[0][0], fast_batt_monitor_enable)
      `CHK("pin_en", v[1][0], wake_pin_enable)
      `CHK("pulls", {v[2][1:0] == 2'b11, v[2][1:0] == 2'b10,
        v[2][1:0] == 2'b01},
        {wake_pin_pull_auto, wake_pin_pull_up, wake_pin_pull_down})
      `CHK("pull_cfg", v[2][1:0], wake_pin_pull_cfg)
      `CHK("fast", v[3][7:6], {xcvr_two_fast, xcvr_one_fast})
      `CHK("modes", v[3][5:0], {xcvr_two_mode, xcvr_one_mode})
      idle(3);
    end
    // every mode code under sleep and stop, both error levels
    for (int k = 0; k < 64; k++) begin
      d = {2'($random(seed)), ~k[3:1], k[3:1]};
      wr(7'h0a, d);
      idle(3);
      system_error_flag = k[5:4];
      ev(k[0] ? 1 : 0);
      d = {d[7:6], nx(d[5:3], k[5], !k[0]), nx(d[2:0], k[4], !k[0])};
      rd(7'h0a, d);
      idle(3);
      `CHK("modes", d[5:0], {xcvr_two_mode, xcvr_one_mode})
    end
    // fail-safe lands on the apply edge of a host write
    wr(7'h0a, 8'he3);
    idle(3);
    wr(7'h07, 8'h00);
    ev(2);
    idle(1);
    rd(7'h07, 8'h01);
    rd(7'h0a, 8'he9);
    idle(3);
    // watchdog stop bit: hardware beats a host write, then a plain pulse
    wr(7'h06, 8'h00);
    {frame_valid, wdog_stop_hw_we, wdog_stop_hw_val} = 3'b011;
    tick;
    idle(2);
    `CHK("wdog_hw", 1'b1, wdog_stop_disable_hi)
    {wdog_stop_hw_we, wdog_stop_hw_val} = 2'b10;
    tick;
    idle(2);
    `CHK("wdog_hw", 1'b0, wdog_stop_disable_hi)
    // soft reset restores the reset image
    soft_reset = 1'b1;
    tick;
    idle(2);
    chk_rst;
    idle(4);
    wrap_up;
  end
endmodule

`default_nettype wire
